// [rtl/msd_pkg.sv]
// Constants, register map and shared decode for the memory address/data scrambler.
// Assumes one test clock; registers sit behind an AXI4-Lite slave with 32-bit data.
//
// Operation
// - Address splits into row bits selecting a row and column bits selecting a word.
// - Bit k of every word on a row is multiplexed onto data line k.
// - Words per row is columns over word width; rows are words over words per row.
// - 1024x32 with 4:1 mux gives 256 rows, 128 columns, 10/8/2 address bits.
// - Column address bits drive the column multiplexer selects on the read side.
// - Write data is steered by column address onto the selected word's bitlines.
// - Fractional base-two logarithms of counts round up to the next whole width.
// - Consecutive addresses select consecutive words; bits inside a word ascend.
// - Patterns are made in logical order; a configurable mapping places them physically.
// - Physical address and data come from logical values through logic operations.
// - Pair-swapped rows: physical row bit 0 is logical row bit 0 xor bit 1.
// - Four-word rows: physical column bit 0 is c1, bit 1 is c0 xor c1.
// - One data bit placed alone with same bits of neighbours adjacent means grouping 1.
// - Logical column values count columns in plain order; reordering only via mapping.
// - Unconfigured bit grouping defaults to the full word width.
// - Unconfigured address and data mapping is identity.
// - Data mapping may combine xor, and, inversion of data, row and column bits.

package msd_pkg;

   // ****************************************
   // Geometry defaults
   // ****************************************
   localparam int MSD_WORDS = 1024;
   localparam int MSD_WORD_W = 32;
   localparam int MSD_COLMUX = 4;
   localparam int MSD_AXI_AW = 12;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [11:0] MSD_OFF_CTRL = 12'h000;
   localparam logic [11:0] MSD_OFF_GROUP = 12'h004;
   localparam logic [11:0] MSD_OFF_STATUS = 12'h008;
   localparam logic [11:0] MSD_OFF_GEOM = 12'h00C;
   localparam logic [11:0] MSD_OFF_AMAP = 12'h040;
   localparam logic [11:0] MSD_OFF_DMAP = 12'h080;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int MSD_CTRL_MAP_EN = 0;
   localparam int MSD_CTRL_CLR = 1;
   localparam int MSD_STAT_FAIL = 0;
   localparam int MSD_STAT_CNT_LSB = 16;
   localparam int MSD_GEOM_NRA_LSB = 0;
   localparam int MSD_GEOM_NCA_LSB = 8;
   localparam int MSD_GEOM_WW_LSB = 16;
   localparam int MSD_AMAP_INV = 16;
   localparam int MSD_DMAP_SRC_LSB = 0;
   localparam int MSD_DMAP_INV = 5;
   localparam int MSD_DMAP_AND_EN = 6;
   localparam int MSD_DMAP_AND_CINV = 7;
   localparam int MSD_DMAP_ROWM_LSB = 8;
   localparam int MSD_DMAP_AND_ROW_LSB = 16;
   localparam int MSD_DMAP_AND_COL_LSB = 20;
   localparam int MSD_DMAP_COLM_LSB = 24;
   localparam int MSD_MAX_ADDR_W = 16;
   localparam int MSD_MAX_NRA = 8;
   localparam int MSD_MAX_NCA = 4;

   // ****************************************
   // Writable masks and reset values
   // ****************************************
   localparam logic [31:0] MSD_CTRL_WMASK = 32'h0000_0001;
   localparam logic [31:0] MSD_GROUP_WMASK = 32'h0000_003F;
   localparam logic [31:0] MSD_AMAP_WMASK = 32'h0001_FFFF;
   localparam logic [31:0] MSD_DMAP_WMASK = 32'h0F37_FFFF;
   localparam logic MSD_CTRL_RST_MAP_EN = 1'b1;

   // ****************************************
   // Register select codes
   // ****************************************
   typedef enum logic [2:0] {
      MSD_SEL_NONE, MSD_SEL_CTRL, MSD_SEL_GROUP, MSD_SEL_STATUS,
      MSD_SEL_GEOM, MSD_SEL_AMAP, MSD_SEL_DMAP
   } msd_sel_e;

   // Bounded bit pick; out-of-range index reads zero
   function automatic logic msdPick(input logic [31:0] vec, input int unsigned idx, input int unsigned n);
      msdPick = (idx < n) ? vec[idx] : 1'b0;
   endfunction

endpackage

// [rtl/msd_addr_map.sv]
// Logical to physical address translation, one xor network per physical bit.
// Assumes map words come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none

module msd_addr_map import msd_pkg::*; #(
   parameter int ADDR_W = 10
) (
   // Logical side
   input wire logic [ADDR_W-1:0] logAddr,
   // Configuration
   input wire logic mapEn,
   input wire logic [ADDR_W-1:0][31:0] addressScrambleMap,
   // Physical side
   output logic [ADDR_W-1:0] physAddr
);

   genvar i;
   generate
      for (i = 0; i < ADDR_W; i++) begin : g_bit
         // Parity of selected logical bits, optional inversion
         assign physAddr[i] = mapEn ?
            ((^(logAddr & addressScrambleMap[i][ADDR_W-1:0])) ^ addressScrambleMap[i][MSD_AMAP_INV]) :
            logAddr[i];
      end
   endgenerate

endmodule

`default_nettype wire

// [rtl/msd_data_map.sv]
// Logical to physical data translation: source pick, inversion, row/column xor and an and term.
// Assumes map words come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none

module msd_data_map import msd_pkg::*; #(
   parameter int WORD_W = 32,
   parameter int NRA = 8,
   parameter int NCA = 2
) (
   // Logical side
   input wire logic [WORD_W-1:0] logData,
   input wire logic [NRA-1:0] logRow,
   input wire logic [NCA-1:0] logCol,
   // Configuration
   input wire logic mapEn,
   input wire logic [WORD_W-1:0][31:0] dataScrambleMap,
   // Physical side
   output logic [WORD_W-1:0] physData
);

   logic [31:0] dataWide;
   logic [31:0] rowWide;
   logic [31:0] colWide;

   assign dataWide = 32'(logData);
   assign rowWide = 32'(logRow);
   assign colWide = 32'(logCol);

   genvar j;
   generate
      for (j = 0; j < WORD_W; j++) begin : g_bit
         logic [31:0] m;
         logic srcBit;
         logic rowTerm;
         logic colTerm;
         logic andTerm;
         assign m = dataScrambleMap[j];
         assign srcBit = msdPick(dataWide, int'(m[MSD_DMAP_SRC_LSB +: 5]), WORD_W);
         assign rowTerm = ^(logRow & m[MSD_DMAP_ROWM_LSB +: NRA]);
         assign colTerm = ^(logCol & m[MSD_DMAP_COLM_LSB +: NCA]);
         assign andTerm = m[MSD_DMAP_AND_EN] &
            msdPick(rowWide, int'(m[MSD_DMAP_AND_ROW_LSB +: 3]), NRA) &
            (msdPick(colWide, int'(m[MSD_DMAP_AND_COL_LSB +: 2]), NCA) ^ m[MSD_DMAP_AND_CINV]);
         assign physData[j] = mapEn ?
            (srcBit ^ m[MSD_DMAP_INV] ^ rowTerm ^ colTerm ^ andTerm) :
            logData[j];
      end
   endgenerate

endmodule

`default_nettype wire

// [rtl/msd_scrambler.sv]
// Top of the memory address/data scrambler with its AXI4-Lite register file.
// Assumes pattern generator, memory pins and bus all run on clock; no pin sync needed.
`timescale 1ns/1ps
`default_nettype none

module msd_scrambler import msd_pkg::*; #(
   parameter int WORDS = MSD_WORDS,
   parameter int WORD_W = MSD_WORD_W,
   parameter int COLMUX = MSD_COLMUX
) (
   // Clock, reset, enable
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ce,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [MSD_AXI_AW-1:0] awaddr,
   input wire logic [2:0] awprot,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [MSD_AXI_AW-1:0] araddr,
   input wire logic [2:0] arprot,
   // AXI4-Lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Pattern generator side, logical values
   input wire logic [$clog2(WORDS)-1:0] logAddr,
   input wire logic [WORD_W-1:0] logWrData,
   input wire logic [WORD_W-1:0] logExpData,
   input wire logic logWrEn,
   input wire logic logRdEn,
   input wire logic logCompare,
   // Memory pins, physical values
   output logic [$clog2(WORDS/COLMUX)-1:0] physicalRowSelect,
   output logic [$clog2(COLMUX)-1:0] physicalColumnSelect,
   output logic [COLMUX-1:0] columnMuxSelect,
   output logic [WORD_W-1:0] memWrData,
   output logic memWe,
   output logic memRe,
   input wire logic [WORD_W-1:0] memRdData,
   // Compare result
   output logic [WORD_W-1:0] expPhysData,
   output logic cmpFail
);

   // ****************************************
   // Geometry
   // ****************************************
   localparam int NROW = WORDS / COLMUX;
   localparam int NCOL = WORD_W * COLMUX;
   localparam int ADDR_W = $clog2(WORDS);
   localparam int NRA = $clog2(NROW);
   localparam int NCA = $clog2(COLMUX);
   localparam logic [5:0] GROUP_DEFAULT = 6'(WORD_W);

   initial begin
      if (COLMUX < 2 || WORDS % COLMUX != 0 || NCOL != WORD_W * COLMUX) begin
         $error("msd_scrambler: words must split evenly into rows of at least two words");
      end
      if (WORD_W < 1 || WORD_W > 32 || ADDR_W > MSD_MAX_ADDR_W) begin
         $error("msd_scrambler: word width or address width out of range");
      end
      if (NRA > MSD_MAX_NRA || NCA > MSD_MAX_NCA || NRA + NCA != ADDR_W) begin
         $error("msd_scrambler: row/column address split not supported");
      end
   end

   // ****************************************
   // Identity reset maps
   // ****************************************
   function automatic logic [ADDR_W-1:0][31:0] amapIdentity();
      logic [ADDR_W-1:0][31:0] r;
      r = '0;
      for (int i = 0; i < ADDR_W; i++) begin
         r[i][i] = 1'b1;
      end
      return r;
   endfunction

   function automatic logic [WORD_W-1:0][31:0] dmapIdentity();
      logic [WORD_W-1:0][31:0] r;
      r = '0;
      for (int j = 0; j < WORD_W; j++) begin
         r[j][MSD_DMAP_SRC_LSB +: 5] = 5'(j);
      end
      return r;
   endfunction

   localparam logic [ADDR_W-1:0][31:0] AMAP_RST = amapIdentity();
   localparam logic [WORD_W-1:0][31:0] DMAP_RST = dmapIdentity();

   // ****************************************
   // Register decode
   // ****************************************
   function automatic msd_sel_e regSel(input logic [MSD_AXI_AW-1:0] a);
      logic [11:0] a12;
      a12 = 12'(a);
      regSel = MSD_SEL_NONE;
      if (a12[1:0] == 2'b00) begin
         if (a12 == MSD_OFF_CTRL) begin
            regSel = MSD_SEL_CTRL;
         end else if (a12 == MSD_OFF_GROUP) begin
            regSel = MSD_SEL_GROUP;
         end else if (a12 == MSD_OFF_STATUS) begin
            regSel = MSD_SEL_STATUS;
         end else if (a12 == MSD_OFF_GEOM) begin
            regSel = MSD_SEL_GEOM;
         end else if (a12 >= MSD_OFF_AMAP && a12 < MSD_OFF_AMAP + 12'(4 * ADDR_W)) begin
            regSel = MSD_SEL_AMAP;
         end else if (a12 >= MSD_OFF_DMAP && a12 < MSD_OFF_DMAP + 12'(4 * WORD_W)) begin
            regSel = MSD_SEL_DMAP;
         end
      end
   endfunction

   function automatic logic [31:0] strbMerge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb, input logic [31:0] wmask);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r & wmask;
   endfunction

   // ****************************************
   // State
   // ****************************************
   typedef enum logic [1:0] {
      MSD_WR_WAIT = 2'b01,
      MSD_WR_RESP = 2'b10
   } msd_wr_e;

   typedef struct packed {
      msd_wr_e wrState;
      logic awHave;
      logic [MSD_AXI_AW-1:0] awAddr;
      logic wHave;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic mapEn;
      logic [5:0] adjacentBitGroupSize;
      logic failSticky;
      logic [15:0] failCount;
      logic [ADDR_W-1:0][31:0] addressScrambleMap;
      logic [WORD_W-1:0][31:0] dataScrambleMap;
   } msd_state_s;

   localparam msd_state_s ST_RST = '{
      wrState: MSD_WR_WAIT, awHave: 1'b0, awAddr: '0, wHave: 1'b0, wData: '0, wStrb: '0,
      bresp: 2'b00, rvalid: 1'b0, rdata: '0, rresp: 2'b00, mapEn: MSD_CTRL_RST_MAP_EN,
      adjacentBitGroupSize: GROUP_DEFAULT, failSticky: 1'b0, failCount: '0,
      addressScrambleMap: AMAP_RST, dataScrambleMap: DMAP_RST
   };

   msd_state_s st;
   msd_state_s next_st;

   // ****************************************
   // Translation datapath
   // ****************************************
   logic [ADDR_W-1:0] physAddr;
   logic [NRA-1:0] logRow;
   logic [NCA-1:0] logCol;

   // Row bits high, column bits low, so consecutive addresses walk a row
   assign logRow = logAddr[ADDR_W-1:NCA];
   assign logCol = logAddr[NCA-1:0];

   msd_addr_map #(
      .ADDR_W(ADDR_W)
   ) uAddrMap (
      .logAddr(logAddr),
      .mapEn(st.mapEn),
      .addressScrambleMap(st.addressScrambleMap),
      .physAddr(physAddr)
   );

   msd_data_map #(
      .WORD_W(WORD_W),
      .NRA(NRA),
      .NCA(NCA)
   ) uWrMap (
      .logData(logWrData),
      .logRow(logRow),
      .logCol(logCol),
      .mapEn(st.mapEn),
      .dataScrambleMap(st.dataScrambleMap),
      .physData(memWrData)
   );

   msd_data_map #(
      .WORD_W(WORD_W),
      .NRA(NRA),
      .NCA(NCA)
   ) uExpMap (
      .logData(logExpData),
      .logRow(logRow),
      .logCol(logCol),
      .mapEn(st.mapEn),
      .dataScrambleMap(st.dataScrambleMap),
      .physData(expPhysData)
   );

   assign physicalRowSelect = physAddr[ADDR_W-1:NCA];
   assign physicalColumnSelect = physAddr[NCA-1:0];

   // One-hot column select shared by read mux and write steering
   always_comb begin
      columnMuxSelect = '0;
      columnMuxSelect[physicalColumnSelect] = logWrEn | logRdEn;
   end

   assign memWe = logWrEn;
   assign memRe = logRdEn;
   assign cmpFail = logCompare & (memRdData != expPhysData);

   // ****************************************
   // Bus handshakes
   // ****************************************
   assign awready = !st.awHave && (st.wrState == MSD_WR_WAIT);
   assign wready = !st.wHave && (st.wrState == MSD_WR_WAIT);
   assign bvalid = (st.wrState == MSD_WR_RESP);
   assign bresp = st.bresp;
   assign arready = !st.rvalid;
   assign rvalid = st.rvalid;
   assign rdata = st.rdata;
   assign rresp = st.rresp;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      msd_sel_e wSel;
      msd_sel_e rSel;
      logic [31:0] rVal;
      logic clrReq;
      logic [31:0] merged;
      int unsigned wIdx;
      int unsigned rIdx;
      next_st = st;
      wSel = regSel(st.awAddr);
      rSel = regSel(araddr);
      rVal = '0;
      clrReq = 1'b0;
      merged = '0;
      wIdx = 0;
      rIdx = 0;

      // Write address and data in either order
      if (awvalid && awready) begin
         next_st.awHave = 1'b1;
         next_st.awAddr = awaddr;
      end
      if (wvalid && wready) begin
         next_st.wHave = 1'b1;
         next_st.wData = wdata;
         next_st.wStrb = wstrb;
      end

      case (st.wrState)
         MSD_WR_WAIT: begin
            if (st.awHave && st.wHave) begin
               next_st.awHave = 1'b0;
               next_st.wHave = 1'b0;
               next_st.bresp = 2'b00;
               next_st.wrState = MSD_WR_RESP;
               case (wSel)
                  MSD_SEL_CTRL: begin
                     merged = strbMerge(32'(st.mapEn), st.wData, st.wStrb, MSD_CTRL_WMASK);
                     next_st.mapEn = merged[MSD_CTRL_MAP_EN];
                     clrReq = st.wStrb[0] & st.wData[MSD_CTRL_CLR];
                  end
                  MSD_SEL_GROUP: begin
                     merged = strbMerge(32'(st.adjacentBitGroupSize), st.wData, st.wStrb, MSD_GROUP_WMASK);
                     next_st.adjacentBitGroupSize = merged[5:0];
                     // Zero means unconfigured: full word
                     if (next_st.adjacentBitGroupSize == 6'h00) begin
                        next_st.adjacentBitGroupSize = GROUP_DEFAULT;
                     end
                  end
                  MSD_SEL_AMAP: begin
                     wIdx = int'(st.awAddr - MSD_AXI_AW'(MSD_OFF_AMAP)) >> 2;
                     next_st.addressScrambleMap[wIdx] = strbMerge(st.addressScrambleMap[wIdx],
                        st.wData, st.wStrb, MSD_AMAP_WMASK);
                  end
                  MSD_SEL_DMAP: begin
                     wIdx = int'(st.awAddr - MSD_AXI_AW'(MSD_OFF_DMAP)) >> 2;
                     next_st.dataScrambleMap[wIdx] = strbMerge(st.dataScrambleMap[wIdx],
                        st.wData, st.wStrb, MSD_DMAP_WMASK);
                  end
                  MSD_SEL_STATUS, MSD_SEL_GEOM: begin
                     next_st.bresp = 2'b00;
                  end
                  default: begin
                     next_st.bresp = 2'b10;
                  end
               endcase
            end
         end
         MSD_WR_RESP: begin
            if (bready) begin
               next_st.wrState = MSD_WR_WAIT;
            end
         end
         default: begin
            next_st.wrState = MSD_WR_WAIT;
         end
      endcase

      // Read channel
      if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_st.rvalid = 1'b1;
         next_st.rresp = 2'b00;
         case (rSel)
            MSD_SEL_CTRL: begin
               rVal[MSD_CTRL_MAP_EN] = st.mapEn;
            end
            MSD_SEL_GROUP: begin
               rVal[5:0] = st.adjacentBitGroupSize;
            end
            MSD_SEL_STATUS: begin
               rVal[MSD_STAT_FAIL] = st.failSticky;
               rVal[MSD_STAT_CNT_LSB +: 16] = st.failCount;
            end
            MSD_SEL_GEOM: begin
               rVal[MSD_GEOM_NRA_LSB +: 8] = 8'(NRA);
               rVal[MSD_GEOM_NCA_LSB +: 8] = 8'(NCA);
               rVal[MSD_GEOM_WW_LSB +: 8] = 8'(WORD_W);
            end
            MSD_SEL_AMAP: begin
               rIdx = int'(araddr - MSD_AXI_AW'(MSD_OFF_AMAP)) >> 2;
               rVal = st.addressScrambleMap[rIdx];
            end
            MSD_SEL_DMAP: begin
               rIdx = int'(araddr - MSD_AXI_AW'(MSD_OFF_DMAP)) >> 2;
               rVal = st.dataScrambleMap[rIdx];
            end
            default: begin
               next_st.rresp = 2'b10;
            end
         endcase
         next_st.rdata = rVal;
      end

      // Compare failures: a new failure beats a clear in the same cycle
      if (clrReq) begin
         next_st.failSticky = 1'b0;
         next_st.failCount = '0;
      end
      if (cmpFail) begin
         next_st.failSticky = 1'b1;
         if (clrReq) begin
            next_st.failCount = 16'h0001;
         end else if (st.failCount != 16'hFFFF) begin
            next_st.failCount = st.failCount + 16'h0001;
         end
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st <= ST_RST;
      end else if (ce) begin
         st <= next_st;
      end
   end

   logic unusedProt;
   assign unusedProt = ^{awprot, arprot};

endmodule

`default_nettype wire

// [testbench/msd_scrambler_asserts.sv]
// Port-level checks for the scrambler top.
// Assumes one clock domain with an active-low reset.
`timescale 1ns/1ps
`default_nettype none
module msd_scrambler_asserts import msd_pkg::*; #(
   parameter int WORDS = MSD_WORDS,
   parameter int WORD_W = MSD_WORD_W,
   parameter int COLMUX = MSD_COLMUX
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ce,
   // Bus
   input wire logic awready,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   // Pattern and memory side
   input wire logic logWrEn,
   input wire logic logRdEn,
   input wire logic logCompare,
   input wire logic [$clog2(COLMUX)-1:0] physicalColumnSelect,
   input wire logic [COLMUX-1:0] columnMuxSelect,
   input wire logic memWe,
   input wire logic memRe,
   input wire logic [WORD_W-1:0] memRdData,
   input wire logic [WORD_W-1:0] expPhysData,
   input wire logic cmpFail
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   strobe_follow_a: assert property (memWe == logWrEn && memRe == logRdEn)
      else $error("memory strobes differ from generator");
   mux_onehot_a: assert property ((logWrEn || logRdEn) |-> columnMuxSelect == COLMUX'(1 << physicalColumnSelect))
      else $error("column mux select wrong");
   mux_idle_a: assert property (!(logWrEn || logRdEn) |-> columnMuxSelect == '0)
      else $error("column mux select active while idle");
   cmp_same_a: assert property (cmpFail == (logCompare && memRdData != expPhysData))
      else $error("compare result wrong");
   b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   ar_block_a: assert property (rvalid |-> !arready)
      else $error("read address taken while busy");
   r_answer_a: assert property (arvalid && arready && ce |=> rvalid)
      else $error("read answer late");
   b_block_a: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while response pending");
   cover property (bvalid && bready);
   cover property (rvalid && rready);
   cover property (cmpFail);
endmodule
bind msd_scrambler msd_scrambler_asserts #(.WORDS(WORDS), .WORD_W(WORD_W), .COLMUX(COLMUX)) chk_u (.*);
`default_nettype wire

// [testbench/msd_mem_model.sv]
// Behavioural memory array on the physical pins.
// Assumes 256 rows of four 32-bit words.
`timescale 1ns/1ps
`default_nettype none
module msd_mem_model import msd_pkg::*; (
   // Clock
   input wire logic clock,
   // Physical pins
   input wire logic [7:0] physicalRowSelect,
   input wire logic [1:0] physicalColumnSelect,
   input wire logic memWe,
   input wire logic memRe,
   input wire logic [31:0] memWrData,
   output logic [31:0] memRdData
);
   logic [31:0] cells [0:1023];
   logic [31:0] lastRd = 32'h0000_0000;
   wire logic [9:0] idx = {physicalRowSelect, physicalColumnSelect};
   // Word picked by column within the row
   always @(posedge clock) begin
      if (memWe) begin
         cells[idx] <= memWrData;
      end
      lastRd <= memRdData;
   end
   // Unselected output keeps changing
   assign memRdData = memRe ? cells[idx] : ~lastRd;
endmodule
`default_nettype wire

// [testbench/msd_scrambler_tb.sv]
// Self-checking bench for the scrambler top.
// Assumes the memory model on the pins and a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module msd_scrambler_tb import msd_pkg::*; ;
   logic clock = 0;
   logic rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic logWrEn = 0, logRdEn = 0, logCompare = 0, mapOn = 0, ce = 1;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, logWrData = 0, logExpData = 0, rdata, memWrData, memRdData, expPhysData;
   logic [9:0] logAddr = 0;
   logic [7:0] physicalRowSelect;
   logic [1:0] physicalColumnSelect, bresp, rresp;
   logic [3:0] columnMuxSelect;
   logic awready, wready, bvalid, arready, rvalid, memWe, memRe, cmpFail;
   int miscompares = 0, n_tests = 0, cyc = 0;
   always #20 clock = ~clock;
   msd_scrambler dut_u (.awprot(3'h0), .arprot(3'h0), .wstrb(4'hF), .*);
   msd_mem_model mem_u (.*);
   // ****************************************
   // Checks and bus cycles
   // ****************************************
   task results();
      $display("miscompares %0d n_tests %0d", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [1:0] rsp);
      if (wr) begin
         awaddr <= a;
         wdata <= d;
         awvalid <= 1;
         wvalid <= 1;
         @(posedge clock);
         while (awvalid || wvalid) begin
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            @(posedge clock);
         end
         bready <= 1;
         do @(posedge clock); while (!bvalid);
         bready <= 0;
         chk(bresp, rsp);
      end else begin
         araddr <= a;
         arvalid <= 1;
         do @(posedge clock); while (!arready);
         arvalid <= 0;
         rready <= 1;
         do @(posedge clock); while (!rvalid);
         rready <= 0;
         chk(rdata, d);
         chk(rresp, rsp);
      end
   endtask
   function automatic logic [9:0] expAddr(input logic [9:0] a, input logic on);
      expAddr = a;
      if (on) begin
         expAddr[2] = a[2] ^ a[3];
         expAddr[0] = a[1];
         expAddr[1] = a[0] ^ a[1];
      end
   endfunction
   function automatic logic [31:0] expData(input logic [31:0] d, input logic [9:0] a, input logic on);
      expData = d;
      if (on) begin
         expData[0] = d[0] ^ a[0];
         expData[1] = d[1] ^ a[0] ^ (a[8] & ~a[0]);
         expData[2] = ~d[1] ^ a[3];
      end
   endfunction
   task pat(input int n);
      repeat (n) begin
         logAddr <= 10'($urandom);
         logWrData <= $urandom;
         logExpData <= $urandom;
         {logWrEn, logRdEn} <= 2'($urandom);
         @(negedge clock);
         chk({physicalRowSelect, physicalColumnSelect}, expAddr(logAddr, mapOn));
         chk(memWrData, expData(logWrData, logAddr, mapOn));
         chk(expPhysData, expData(logExpData, logAddr, mapOn));
         @(posedge clock);
      end
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares++;
         results();
      end
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      void'($urandom(81));
      repeat (12) @(posedge clock);
      rst_b <= 1;
      @(posedge clock);
      pat(16);
      bus(0, 12'h00C, 32'h0020_0208, 2'b00);
      bus(0, 12'h004, 32'h0000_0020, 2'b00);
      bus(1, 12'h004, 32'h0000_0000, 2'b00);
      bus(0, 12'h004, 32'h0000_0020, 2'b00);
      bus(1, 12'h200, 32'hFFFF_FFFF, 2'b10);
      bus(0, 12'h200, 32'h0000_0000, 2'b10);
      bus(1, 12'h040, 32'h0000_0002, 2'b00);
      bus(1, 12'h044, 32'h0000_0003, 2'b00);
      bus(1, 12'h048, 32'h0000_000C, 2'b00);
      bus(1, 12'h080, 32'h0100_0000, 2'b00);
      bus(1, 12'h084, 32'h0106_00C1, 2'b00);
      bus(1, 12'h088, 32'h0000_0221, 2'b00);
      bus(0, 12'h048, 32'h0000_000C, 2'b00);
      mapOn = 1;
      pat(40);
      logAddr <= 10'h2B7;
      logWrData <= 32'hA5A5_0F0F;
      {logWrEn, logRdEn} <= 2'b10;
      @(posedge clock);
      {logWrEn, logRdEn, logCompare} <= 3'b011;
      logExpData <= 32'hA5A5_0F0F;
      @(negedge clock);
      chk(cmpFail, 0);
      @(posedge clock);
      logExpData <= 32'hA5A5_0F0E;
      ce <= 0;
      @(negedge clock);
      chk(cmpFail, 1);
      @(posedge clock);
      ce <= 1;
      @(posedge clock);
      {logRdEn, logCompare} <= 2'b00;
      bus(0, 12'h008, 32'h0001_0001, 2'b00);
      bus(1, 12'h000, 32'h0000_0003, 2'b00);
      bus(0, 12'h008, 32'h0000_0000, 2'b00);
      bus(0, 12'h000, 32'h0000_0001, 2'b00);
      bus(1, 12'h000, 32'h0000_0000, 2'b00);
      mapOn = 0;
      pat(16);
      results();
   end
endmodule
`default_nettype wire
